// ==== asi_tx_ch7_ch8_slot_map_tb_top.sv ====
// Self-checking bench for the channel 7/8 slot mapper: registers, then random frames.
// Assumes the host model captures one data bit per bit clock period.
`timescale 1ns/1ps
module asi_tx_ch7_ch8_slot_map_tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [1:0]  fmt = 2'b00;
  logic [15:0] echo_a = 16'h0000;
  logic [15:0] echo_b = 16'h0000;
  logic [31:0] link = 32'h0000_0000;
  logic [31:0] rng = 32'h0001_54af;
  logic [31:0] r;
  logic [1:0]  e;
  logic        bclk, fsync, sd_o, sd_oe;
  int          fails = 0, total_checks = 0, m7, m8, f;
  logic [1:0]  q[$];

  always #2.5 clk = ~clk;

  tx_ch78_slot_map dut(.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk(bclk), .fsync(fsync),
    .format(tx_slot_pkg::frame_format_t'(fmt)), .echo_reference_first(echo_a),
    .echo_reference_second(echo_b), .inter_chip_link_data(link), .sdout_o(sd_o),
    .sdout_oe(sd_oe));

  host_serial_model host(.clk(clk), .bclk(bclk), .fsync(fsync), .sdout_o(sd_o), .sdout_oe(sd_oe));

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Keeps random slot numbers inside the four or eight slots that a short frame carries.
  function automatic logic [4:0] sl(input logic [4:0] v, input int fm);
    return (fm == 0) ? {2'b00, v[2:0]} : {v[4], 2'b00, v[1:0]};
  endfunction

  function automatic logic [1:0] expect_bit(input int p, input int fm);
    int slot, pos, b;
    logic [31:0] w7;
    slot = p / 32;
    b = 31 - p % 32;
    pos = (fm == 0) ? slot : ((((slot < 4) ^ (fm == 2)) ? 16 : 0) + slot % 4);
    w7 = {echo_a, echo_b};
    if (m7[6:5] == 2 && m7[4:0] == pos) return {1'b1, w7[b]};
    if (m8[5] && m8[4:0] == pos) return {1'b1, link[b]};
    return 2'b00;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    if (a == 8'h24) m7 = d & 8'h7f;
    if (a == 8'h25) m8 = d & 8'h3f;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check(reg_rdata, exp, "read data");
  endtask

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    m7 = 8'h06;
    m8 = 8'h07;
    rd(8'h24, 8'h06);
    rd(8'h25, 8'h07);
    wr(8'h24, 8'hff);
    wr(8'h25, 8'hff);
    rd(8'h24, 8'h7f);
    rd(8'h25, 8'h3f);
    rd(8'h30, 8'h00);
    @(negedge clk);
    check(reg_rdata, 8'h00, "idle read data");
    for (int i = 0; i < 12; i++)
    begin
      r = rnd();
      f = i % 3;
      wr(8'h24, {1'b0, 2'(i % 4), sl(r[4:0], f)});
      wr(8'h25, {2'b00, r[16], sl(r[12:8], f)});
      rd(8'h24, 8'(m7));
      rd(8'h25, 8'(m8));
      @(posedge clk);
      fmt <= 2'(f);
      echo_a <= 16'(rnd());
      echo_b <= 16'(rnd());
      link <= rnd();
      host.frame(f == 0, 4);
      for (int p = 0; p < 256; p++) q.push_back(expect_bit(p, f));
      for (int p = 0; p < 256; p++)
      begin
        e = q.pop_front();
        check({host.cap_oe[p], e[1] & host.cap_o[p]}, e, "data line");
      end
    end
    @(posedge clk);
    arst_n <= 1'b0;
    @(negedge clk);
    check({reg_rdata, sd_oe}, 9'h000, "outputs during reset");
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    m7 = 8'h06;
    m8 = 8'h07;
    rd(8'h24, 8'h06);
    rd(8'h25, 8'h07);
    complete_run();
  end
endmodule

// ==== host_serial_model.sv ====
// Behavioural serial host: makes bit clock and frame sync and captures the data line.
// Assumes the device launches each bit well inside half a bit clock period.
`timescale 1ns/1ps
module host_serial_model
#(
  parameter int HALF = 8
)
(
  input  wire logic clk,
  output logic      bclk,
  output logic      fsync,
  input  wire logic sdout_o,
  input  wire logic sdout_oe
);
  logic cap_oe [0:255];
  logic cap_o  [0:255];

  initial
  begin
    bclk  = 1'b0;
    fsync = 1'b0;
  end

  function automatic logic sync_level(input logic tdm, input int p, input int nslots);
    return tdm ? (p == 0) : (p < nslots * 32);
  endfunction

  // The bit clock stands still between frames; frame sync moves only while it is low.
  task automatic frame(input logic tdm, input int nslots);
    fsync <= sync_level(tdm, 0, nslots);
    repeat (HALF) @(posedge clk);
    for (int p = 0; p < nslots * 64; p++)
    begin
      bclk <= 1'b1;
      repeat (HALF) @(posedge clk);
      bclk  <= 1'b0;
      fsync <= sync_level(tdm, p + 1, nslots);
      repeat (HALF) @(posedge clk);
      cap_oe[p] = sdout_oe;
      cap_o[p]  = sdout_o;
    end
  endtask
endmodule

// ==== slot_pos_if.sv ====
// Carries the current slot position and bit launch strobe from the slot tracker.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface slot_pos_if;
  logic [4:0] slot_pos;
  logic [4:0] bit_idx;
  logic       tick;

  modport src
  (
    output slot_pos,
    output bit_idx,
    output tick
  );

  modport dst
  (
    input slot_pos,
    input bit_idx,
    input tick
  );
endinterface

// ==== slot_tracker.sv ====
// Tracks the bit and slot position of the serial frame from the bit clock and frame sync.
// Assumes bclk and fsync are pins from outside the clk domain, well below clk/4.
`timescale 1ns/1ps
module slot_tracker
(
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic                       bclk,
  input  wire logic                       fsync,
  input  wire tx_slot_pkg::frame_format_t format,
  slot_pos_if.src                         pos
);

  logic [2:0] bclk_sync_reg;
  logic [1:0] fs_sync_reg;
  logic       fs_prev_reg;
  logic       right_reg;
  logic [4:0] bit_reg;
  logic [4:0] slot_reg;
  logic       tick_reg;

  wire bclk_rise = bclk_sync_reg[1] & ~bclk_sync_reg[2];
  wire bclk_fall = ~bclk_sync_reg[1] & bclk_sync_reg[2];
  wire fs_s = fs_sync_reg[1];
  wire is_tdm = (format == tx_slot_pkg::FMT_TDM);
  // TDM frames start on the rising frame sync; I2S and LJ restart on each half.
  wire frame_start = is_tdm ? (fs_s & ~fs_prev_reg) : (fs_s ^ fs_prev_reg);
  // I2S has the left half while sync is low, left-justified while it is high.
  wire right_next = (format == tx_slot_pkg::FMT_I2S) ? fs_s : ~fs_s;
  wire last_bit = (bit_reg == 5'(tx_slot_pkg::SLOT_WORD_BITS - 1));

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bclk_sync_reg <= 3'h0;
      fs_sync_reg <= 2'h0;
    end
    else
    begin
      bclk_sync_reg <= {bclk_sync_reg[1:0], bclk};
      fs_sync_reg <= {fs_sync_reg[0], fsync};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fs_prev_reg <= 1'b0;
      right_reg <= 1'b0;
      bit_reg <= 5'h0;
      slot_reg <= 5'h0;
    end
    else if (bclk_rise)
    begin
      fs_prev_reg <= fs_s;
      if (frame_start)
      begin
        bit_reg <= 5'h0;
        slot_reg <= 5'h0;
        right_reg <= right_next;
      end
      else
      begin
        bit_reg <= last_bit ? 5'h0 : bit_reg + 5'h1;
        slot_reg <= last_bit ? slot_reg + 5'h1 : slot_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tick_reg <= 1'b0;
    else
      tick_reg <= bclk_fall;
  end

  // Two-channel formats put the half in the top bit and the slot in the low four.
  assign pos.slot_pos = is_tdm ? slot_reg : {right_reg, slot_reg[3:0]};
  assign pos.bit_idx = bit_reg;
  assign pos.tick = tick_reg;

endmodule

// ==== tx_ch78_slot_map.sv ====
// Transmit slot mapper for serial output channels 7 and 8 with its two config registers.
// Assumes echo and link data words are held stable on clk by the surrounding audio path.
`timescale 1ns/1ps

module tx_ch78_slot_map
(
  input  wire logic                       clk,
  input  wire logic                       arst_n,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata,
  input  wire logic                       bclk,
  input  wire logic                       fsync,
  input  wire tx_slot_pkg::frame_format_t format,
  input  wire logic [15:0]                echo_reference_first,
  input  wire logic [15:0]                echo_reference_second,
  input  wire logic [31:0]                inter_chip_link_data,
  output logic                            sdout_o,
  output logic                            sdout_oe
);

  logic [7:0] ch7_cfg_reg;
  logic [7:0] ch8_cfg_reg;
  logic [7:0] rdata_reg;
  logic       dout_reg;
  logic       oe_reg;

  slot_pos_if pos_bus ();

  slot_tracker u_tracker
  (
    .clk    (clk),
    .arst_n (arst_n),
    .bclk   (bclk),
    .fsync  (fsync),
    .format (format),
    .pos    (pos_bus.src)
  );

  wire wr_ch7 = reg_wr & (reg_addr == tx_slot_pkg::TX_CH7_CFG_ADDR);
  wire wr_ch8 = reg_wr & (reg_addr == tx_slot_pkg::TX_CH8_CFG_ADDR);
  wire rd_ch7 = reg_rd & (reg_addr == tx_slot_pkg::TX_CH7_CFG_ADDR);
  wire rd_ch8 = reg_rd & (reg_addr == tx_slot_pkg::TX_CH8_CFG_ADDR);
  // Reserved bits are masked off so they always read back as zero.
  wire [7:0] ch7_cfg_next = reg_wdata & tx_slot_pkg::TX_CH7_WR_MASK;
  wire [7:0] ch8_cfg_next = reg_wdata & tx_slot_pkg::TX_CH8_WR_MASK;
  wire [7:0] rdata_next = rd_ch7 ? ch7_cfg_reg : (rd_ch8 ? ch8_cfg_reg : 8'h00);

  wire [4:0] ch7_slot = ch7_cfg_reg[tx_slot_pkg::SLOT_FIELD_MSB:0];
  wire [4:0] ch8_slot = ch8_cfg_reg[tx_slot_pkg::SLOT_FIELD_MSB:0];
  wire [1:0] ch7_src = ch7_cfg_reg[tx_slot_pkg::CH7_SRC_MSB:tx_slot_pkg::CH7_SRC_LSB];
  wire       ch8_src = ch8_cfg_reg[tx_slot_pkg::CH8_SRC_BIT];

  wire [31:0] echo_word = {echo_reference_first, echo_reference_second};
  // Words go out MSB first.
  wire [4:0] word_bit = 5'(tx_slot_pkg::SLOT_WORD_BITS - 1) - pos_bus.bit_idx;
  wire echo_bit = echo_word[word_bit];
  wire link_bit = inter_chip_link_data[word_bit];

  wire hit7 = pos_bus.tick & (pos_bus.slot_pos == ch7_slot);
  wire hit8 = pos_bus.tick & (pos_bus.slot_pos == ch8_slot);
  // Reserved channel 7 codes are treated like tri-state.
  wire drive7 = hit7 & (ch7_src == tx_slot_pkg::SRC7_ECHO);
  // Channel 7 wins if both channels are placed in the same slot and channel 7 has its echo source selected.
  wire drive8 = hit8 & ch8_src & ~drive7;
  wire oe_next = drive7 | drive8;
  wire dout_next = drive7 ? echo_bit : (drive8 ? link_bit : 1'b0);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ch7_cfg_reg <= tx_slot_pkg::TX_CH7_CFG_RESET;
      ch8_cfg_reg <= tx_slot_pkg::TX_CH8_CFG_RESET;
    end
    else
    begin
      if (wr_ch7)
        ch7_cfg_reg <= ch7_cfg_next;
      if (wr_ch8)
        ch8_cfg_reg <= ch8_cfg_next;
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= 8'h00;
    else
      rdata_reg <= rdata_next;
  end

  // Output pin state changes only at a bit launch and holds between them.
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      oe_reg <= 1'b0;
      dout_reg <= 1'b0;
    end
    else if (pos_bus.tick)
    begin
      oe_reg <= oe_next;
      dout_reg <= dout_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign sdout_o = dout_reg;
  assign sdout_oe = oe_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  sequence ch7_launch;
    pos_bus.tick && (pos_bus.slot_pos == ch7_slot);
  endsequence

  sequence ch8_alone_launch;
    pos_bus.tick && (pos_bus.slot_pos == ch8_slot) && !drive7;
  endsequence

  // A launch in channel 7's slot while its echo word is selected.
  sequence ch7_echo_launch;
    ch7_launch ##0 (ch7_src == tx_slot_pkg::SRC7_ECHO);
  endsequence

  sequence ch8_link_launch;
    ch8_alone_launch ##0 ch8_src;
  endsequence

  chk_ch7_tristate_off: assert property (
    ch7_launch ##0 (ch7_src != tx_slot_pkg::SRC7_ECHO) ##0 !(hit8 && ch8_src)
      |=> !sdout_oe)
    else $error("channel 7 slot driven while its source is off");

  chk_ch7_echo_bit: assert property (
    ch7_launch ##0 (ch7_src == tx_slot_pkg::SRC7_ECHO)
      |=> sdout_oe && (sdout_o == $past(echo_bit)))
    else $error("channel 7 slot does not carry the echo word bit");

  chk_ch7_slot_write: assert property (
    wr_ch7 |=> ch7_slot == $past(reg_wdata[4:0]))
    else $error("channel 7 slot field not updated by write");

  chk_ch8_slot_write: assert property (
    wr_ch8 |=> ch8_slot == $past(reg_wdata[4:0]))
    else $error("channel 8 slot field not updated by write");

  chk_ch8_link_bit: assert property (
    ch8_alone_launch ##0 ch8_src |=> sdout_oe && (sdout_o == $past(link_bit)))
    else $error("channel 8 slot does not carry the link word bit");

  chk_ch8_tristate_off: assert property (
    ch8_alone_launch ##0 !ch8_src ##0 !hit7 |=> !sdout_oe)
    else $error("channel 8 slot driven while its source is off");

  chk_ch8_reserved_zero: assert property (
    wr_ch8 |=> (ch8_cfg_reg[7:6] == 2'b00) [*2])
    else $error("channel 8 reserved bits took a written value");

  chk_ch7_reserved_zero: assert property (
    wr_ch7 |=> !ch7_cfg_reg[7])
    else $error("channel 7 reserved bit took a written value");

  chk_pin_hold_between: assert property (
    !pos_bus.tick |=> $stable(sdout_oe) && $stable(sdout_o))
    else $error("serial output changed without a bit launch");

  chk_unassigned_slot_quiet: assert property (
    pos_bus.tick && !hit7 && !hit8 |=> !sdout_oe)
    else $error("serial output driven outside an assigned slot");

  chk_read_answer: assert property (
    rd_ch7 |=> reg_rdata == $past(ch7_cfg_reg))
    else $error("register read did not return channel 7 config");

  // Reads answer for one cycle only and are zero otherwise.
  chk_read_ch8_answer: assert property (
    rd_ch8 |=> reg_rdata == $past(ch8_cfg_reg))
    else $error("register read did not return channel 8 config");

  chk_read_idle_zero: assert property (
    !(rd_ch7 || rd_ch8) |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a mapped read");

  // Config registers change only on a write to their own address.
  chk_ch7_cfg_hold: assert property (
    !wr_ch7 |=> $stable(ch7_cfg_reg))
    else $error("channel 7 config changed without a write");

  chk_ch8_cfg_hold: assert property (
    !wr_ch8 |=> $stable(ch8_cfg_reg))
    else $error("channel 8 config changed without a write");

  chk_ch7_reserved_idle: assert property (
    ch7_launch ##0 ch7_src[0] ##0 !(hit8 && ch8_src) |=> !sdout_oe)
    else $error("reserved channel 7 source drove the output");

  // Word order is checked against the input pins, not against the bit select.
  chk_echo_msb_first: assert property (
    ch7_echo_launch ##0 (pos_bus.bit_idx == 5'h00)
      |=> sdout_o == $past(echo_reference_first[15]))
    else $error("channel 7 word does not start with its top bit");

  chk_echo_lsb_last: assert property (
    ch7_echo_launch ##0 (pos_bus.bit_idx == 5'h1f)
      |=> sdout_o == $past(echo_reference_second[0]))
    else $error("channel 7 word does not end with its bottom bit");

  chk_link_msb_first: assert property (
    ch8_link_launch ##0 (pos_bus.bit_idx == 5'h00)
      |=> sdout_o == $past(inter_chip_link_data[31]))
    else $error("channel 8 word does not start with its top bit");

  chk_ch7_wins_slot: assert property (
    ch7_echo_launch ##0 hit8 ##0 ch8_src |=> sdout_oe && (sdout_o == $past(echo_bit)))
    else $error("channel 8 took a slot shared with channel 7");

  chk_tick_one_cycle: assert property (
    pos_bus.tick |=> !pos_bus.tick)
    else $error("bit launch strobe longer than one cycle");

endmodule

// ==== tx_slot_pkg.sv ====
// Constants shared by the channel 7/8 transmit slot mapper.
// Assumes an 8-bit register port and an externally generated bit clock and frame sync.
package tx_slot_pkg;

  localparam logic [7:0] TX_CH7_CFG_ADDR = 8'h24;
  localparam logic [7:0] TX_CH8_CFG_ADDR = 8'h25;
  localparam logic [7:0] TX_CH7_CFG_RESET = 8'h06;
  localparam logic [7:0] TX_CH8_CFG_RESET = 8'h07;
  localparam logic [7:0] TX_CH7_WR_MASK = 8'h7f;
  localparam logic [7:0] TX_CH8_WR_MASK = 8'h3f;
  localparam int SLOT_FIELD_MSB = 4;
  localparam int CH7_SRC_LSB = 5;
  localparam int CH7_SRC_MSB = 6;
  localparam int CH8_SRC_BIT = 5;
  localparam int SLOT_BITS = 5;
  localparam int SLOT_WORD_BITS = 32;

  typedef enum logic [1:0]
  {
    SRC7_TRISTATE = 2'b00,
    SRC7_RESERVED1 = 2'b01,
    SRC7_ECHO = 2'b10,
    SRC7_RESERVED3 = 2'b11
  } ch7_source_t;

  typedef enum logic [1:0]
  {
    FMT_TDM = 2'b00,
    FMT_I2S = 2'b01,
    FMT_LJ = 2'b10
  } frame_format_t;

endpackage
